// file: sbs_params.svh
// Constants for the two-wire serial bus slave interface
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
// Register byte offsets
`define SBS_OFS_CTRL 8'h00
`define SBS_OFS_OWN 8'h04
`define SBS_OFS_DATA 8'h08
`define SBS_OFS_STAT 8'h0C
`define SBS_OFS_ISTAT 8'h10
`define SBS_OFS_IMASK 8'h14
// Control register fields
`define SBS_C_MSEL 0
`define SBS_C_TRX 1
`define SBS_C_PIN 2
`define SBS_C_ACK 3
`define SBS_C_BPW_LO 4
`define SBS_C_BPW_HI 6
// Status register fields
`define SBS_S_LRB 0
`define SBS_S_GC 1
`define SBS_S_AAS 2
`define SBS_S_ARBL 3
`define SBS_S_PIN 4
`define SBS_S_BB 5
`define SBS_S_TRX 6
`define SBS_S_MSEL 7
// Interrupt status and mask fields
`define SBS_I_SVC 0
`define SBS_I_ARBL 1
`define SBS_I_STOP 2
`define SBS_IRQ_W 3
// Reset values and encodings
`define SBS_OWN_RST 7'h00
`define SBS_GC_ADDR 8'h00
`define SBS_BPW_FULL 4'h8
`define SBS_BYTE_ZERO 8'h00
// Clock low period and system clock period
`define SBS_T_LOW_NS 4700
`define SBS_CLK_NS 8
`define SBS_T_LOW_CYC ((`SBS_T_LOW_NS + `SBS_CLK_NS - 1) / `SBS_CLK_NS)
`endif

// file: sbs_pkg.sv
// Types shared by the serial bus slave interface
`default_nettype none
package sbs_pkg;
   typedef logic [7:0] sbs_byte_t;
   typedef logic [7:0] sbs_addr_t;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_BITS,
      ST_ACK,
      ST_HOLD,
      ST_SKIP
   } sbs_state_e;
endpackage
`default_nettype wire

// file: sbs_slave.sv
// Two-wire serial bus interface, slave mode, with register port
//
// Our own choices: the register addresses and the strobed register port.
`include "sbs_params.svh"
`default_nettype none
// Function
// - Slave runs normally or after lost arbitration
// - Slave interrupts on address, general call, word
// - Lost arbitration switches master into slave
// - Interrupt at word end after arbitration loss
// - Interrupt clears pending flag, holds SCL low
// - Buffer access or flag set releases SCL
// - Lost, addressed read: trx1 al1 aas1 gc0
// - Addressed read as slave: trx1 al0 aas1
// - Word sent: trx1 al0 aas0
// - Lost, addressed write: trx0 al1 aas1
// - Lost, word ended: trx0 al1 aas0
// - Addressed write as slave: trx0 al0 aas1
// - Word received: trx0 al0 aas0, read buffer
module sbs_slave #(
   parameter int unsigned T_LOW_CYC = `SBS_T_LOW_CYC,
   parameter logic [6:0] OWN_RST = `SBS_OWN_RST
) (
   input wire logic CLOCK_I, // System clock
   input wire logic SRST_I, // Synchronous reset
   input wire sbs_pkg::sbs_addr_t ADDR_I, // Register address
   input wire sbs_pkg::sbs_byte_t WDATA_I, // Write data
   input wire logic WR_I, // Write strobe
   input wire logic RD_I, // Read strobe
   output var sbs_pkg::sbs_byte_t RDATA_O, // Read data
   output logic IRQ_O, // Interrupt level
   input wire logic SCL_I, // Clock pin level
   output logic SCL_O, // Clock pin drive value
   output logic SCL_OE_O, // Clock pin pull low
   input wire logic SDA_I, // Data pin level
   output logic SDA_O, // Data pin drive value
   output logic SDA_OE_O // Data pin pull low
);
   import sbs_pkg::*;

   logic scl_m_q, scl_s_q, scl_p_q;
   logic sda_m_q, sda_s_q, sda_p_q;
   logic msel_q, trx_q, pin_q, ack_q;
   logic [2:0] bpw_q;
   logic [6:0] own_q;
   sbs_byte_t buf_q, rsh_q, rsh_d, tsh_q, tsh_d, rdata_q;
   logic lrb_q, lrb_d, gc_q, aas_q, arbl_q, bb_q;
   logic [`SBS_IRQ_W-1:0] istat_q, imask_q, ev_w;
   sbs_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d, n_bits;
   logic drv_q, drv_d, adph_q, adph_d;
   logic sdal_q, sdal_d, scll_q;
   logic [15:0] low_q;
   logic svc, arbl_set, aas_set, gc_set, trx_set, trx_clr;
   logic buf_ld;

   // Pin synchronisers
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_m_q <= SCL_I;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= SDA_I;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   // Bus edges and conditions
   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   // Register decode
   logic wr_ctrl, wr_own, wr_data, wr_imask;
   logic rd_data, rd_istat, acc_data;
   assign wr_ctrl = WR_I & (ADDR_I == `SBS_OFS_CTRL);
   assign wr_own = WR_I & (ADDR_I == `SBS_OFS_OWN);
   assign wr_data = WR_I & (ADDR_I == `SBS_OFS_DATA);
   assign wr_imask = WR_I & (ADDR_I == `SBS_OFS_IMASK);
   assign rd_data = RD_I & (ADDR_I == `SBS_OFS_DATA);
   assign rd_istat = RD_I & (ADDR_I == `SBS_OFS_ISTAT);
   assign acc_data = wr_data | rd_data;

   // Word length, zero means a full byte
   assign n_bits = (bpw_q == 3'h0) ? `SBS_BPW_FULL : {1'b0, bpw_q};

   // Address match against own address or general call
   logic own_hit, gc_hit, addressed, low_done;
   assign own_hit = (rsh_q[7:1] == own_q);
   assign gc_hit = (rsh_q == `SBS_GC_ADDR);
   assign addressed = own_hit | gc_hit;
   assign low_done = (low_q >= 16'(T_LOW_CYC));

   // Protocol sequencer
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      rsh_d = rsh_q;
      tsh_d = tsh_q;
      drv_d = drv_q;
      adph_d = adph_q;
      sdal_d = sdal_q;
      lrb_d = lrb_q;
      svc = 1'b0;
      arbl_set = 1'b0;
      aas_set = 1'b0;
      gc_set = 1'b0;
      trx_set = 1'b0;
      trx_clr = 1'b0;
      buf_ld = 1'b0;
      if (stop_c)
      begin
         st_d = ST_IDLE;
         drv_d = 1'b0;
         sdal_d = 1'b0;
      end
      else if (start_c)
      begin
         st_d = ST_BITS;
         cnt_d = 4'h0;
         adph_d = 1'b1;
         drv_d = msel_q & trx_q;
         tsh_d = buf_q;
         sdal_d = 1'b0;
      end
      else
      begin
         case (st_q)
            ST_BITS:
            begin
               // Transmit dropped by software: let the data line go
               if (drv_q & ~trx_q)
               begin
                  drv_d = 1'b0;
                  sdal_d = 1'b0;
               end
               else if (scl_rise)
               begin
                  rsh_d = {rsh_q[6:0], sda_s_q};
                  cnt_d = cnt_q + 4'h1;
                  // Released a one but the line is low
                  if (drv_q & msel_q & ~sdal_q & ~sda_s_q)
                  begin
                     arbl_set = 1'b1;
                     drv_d = 1'b0;
                  end
               end
               else if (scl_fall)
               begin
                  if (cnt_q < n_bits)
                  begin
                     sdal_d = drv_q & ~tsh_q[7];
                     tsh_d = {tsh_q[6:0], 1'b0};
                  end
                  else
                  begin
                     st_d = ST_ACK;
                     if (adph_q)
                     begin
                        if (msel_q)
                           sdal_d = 1'b0;
                        else if (addressed)
                           sdal_d = 1'b1;
                        else if (arbl_q)
                           sdal_d = 1'b0;
                        else
                        begin
                           st_d = ST_SKIP;
                           sdal_d = 1'b0;
                        end
                     end
                     else
                        sdal_d = ~drv_q & ~msel_q & ack_q;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_rise)
                  lrb_d = sda_s_q;
               else if (scl_fall)
               begin
                  sdal_d = 1'b0;
                  st_d = ST_HOLD;
                  svc = 1'b1;
                  adph_d = 1'b0;
                  buf_ld = ~drv_q;
                  if (adph_q & ~msel_q & addressed)
                  begin
                     aas_set = 1'b1;
                     gc_set = gc_hit;
                     trx_set = rsh_q[0] & ~gc_hit;
                     trx_clr = ~rsh_q[0] | gc_hit;
                  end
                  else if (arbl_q)
                     trx_clr = 1'b1;
               end
            end
            ST_HOLD:
            begin
               // Stretch until software service and low period
               if (pin_q & low_done)
               begin
                  st_d = ST_BITS;
                  cnt_d = 4'h0;
                  drv_d = trx_q;
                  sdal_d = trx_q & ~buf_q[7];
                  tsh_d = {buf_q[6:0], 1'b0};
               end
            end
            ST_IDLE, ST_SKIP:
               st_d = st_q;
            default:
               st_d = ST_IDLE;
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         rsh_q <= `SBS_BYTE_ZERO;
         tsh_q <= `SBS_BYTE_ZERO;
         drv_q <= 1'b0;
         adph_q <= 1'b0;
         sdal_q <= 1'b0;
         scll_q <= 1'b0;
         lrb_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rsh_q <= rsh_d;
         tsh_q <= tsh_d;
         drv_q <= drv_d;
         adph_q <= adph_d;
         sdal_q <= sdal_d;
         scll_q <= (st_d == ST_HOLD);
         lrb_q <= lrb_d;
      end
   end

   // Clock low period counter while stretching
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I || st_q != ST_HOLD)
         low_q <= 16'h0000;
      else if (!low_done)
         low_q <= low_q + 16'h0001;
   end

   // Control register and service flag
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         msel_q <= 1'b0;
         trx_q <= 1'b0;
         pin_q <= 1'b1;
         ack_q <= 1'b1;
         bpw_q <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            msel_q <= WDATA_I[`SBS_C_MSEL];
            trx_q <= WDATA_I[`SBS_C_TRX];
            ack_q <= WDATA_I[`SBS_C_ACK];
            bpw_q <= WDATA_I[`SBS_C_BPW_HI:`SBS_C_BPW_LO];
         end
         if (arbl_set)
            msel_q <= 1'b0;
         if (trx_clr)
            trx_q <= 1'b0;
         if (trx_set)
            trx_q <= 1'b1;
         if (svc)
            pin_q <= 1'b0;
         else if (acc_data || (wr_ctrl && WDATA_I[`SBS_C_PIN]))
            pin_q <= 1'b1;
      end
   end

   // Own address and data buffer
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         own_q <= OWN_RST;
         buf_q <= `SBS_BYTE_ZERO;
      end
      else
      begin
         if (wr_own)
            own_q <= WDATA_I[7:1];
         if (buf_ld)
            buf_q <= rsh_q;
         else if (wr_data)
            buf_q <= WDATA_I;
      end
   end

   // Bus status flags
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         arbl_q <= 1'b0;
         aas_q <= 1'b0;
         gc_q <= 1'b0;
         bb_q <= 1'b0;
      end
      else
      begin
         // Writing master select clears lost flag; loss wins
         if (arbl_set)
            arbl_q <= 1'b1;
         else if (wr_ctrl && WDATA_I[`SBS_C_MSEL])
            arbl_q <= 1'b0;
         if (start_c)
            aas_q <= 1'b0;
         else if (aas_set)
            aas_q <= 1'b1;
         else if (svc)
            aas_q <= 1'b0;
         if (start_c)
            gc_q <= 1'b0;
         else if (aas_set)
            gc_q <= gc_set;
         if (start_c)
            bb_q <= 1'b1;
         else if (stop_c)
            bb_q <= 1'b0;
      end
   end

   // Sticky events, read of interrupt status clears, set wins
   assign ev_w[`SBS_I_SVC] = svc;
   assign ev_w[`SBS_I_ARBL] = arbl_set;
   assign ev_w[`SBS_I_STOP] = stop_c;
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         istat_q <= '0;
         imask_q <= '0;
      end
      else
      begin
         istat_q <= (rd_istat ? '0 : istat_q) | ev_w;
         if (wr_imask)
            imask_q <= WDATA_I[`SBS_IRQ_W-1:0];
      end
   end

   // Status and control read views
   sbs_byte_t stat_w, ctrl_w, rd_mux;
   assign stat_w[`SBS_S_LRB] = lrb_q;
   assign stat_w[`SBS_S_GC] = gc_q;
   assign stat_w[`SBS_S_AAS] = aas_q;
   assign stat_w[`SBS_S_ARBL] = arbl_q;
   assign stat_w[`SBS_S_PIN] = pin_q;
   assign stat_w[`SBS_S_BB] = bb_q;
   assign stat_w[`SBS_S_TRX] = trx_q;
   assign stat_w[`SBS_S_MSEL] = msel_q;
   assign ctrl_w[`SBS_C_MSEL] = msel_q;
   assign ctrl_w[`SBS_C_TRX] = trx_q;
   assign ctrl_w[`SBS_C_PIN] = pin_q;
   assign ctrl_w[`SBS_C_ACK] = ack_q;
   assign ctrl_w[`SBS_C_BPW_HI:`SBS_C_BPW_LO] = bpw_q;
   assign ctrl_w[7] = 1'b0;

   // Read selection, unmapped reads as zero
   assign rd_mux =
      (ADDR_I == `SBS_OFS_CTRL) ? ctrl_w :
      (ADDR_I == `SBS_OFS_OWN) ? {own_q, 1'b0} :
      (ADDR_I == `SBS_OFS_DATA) ? buf_q :
      (ADDR_I == `SBS_OFS_STAT) ? stat_w :
      (ADDR_I == `SBS_OFS_ISTAT) ? {5'h00, istat_q} :
      (ADDR_I == `SBS_OFS_IMASK) ? {5'h00, imask_q} :
      `SBS_BYTE_ZERO;

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
         rdata_q <= `SBS_BYTE_ZERO;
      else
         rdata_q <= RD_I ? rd_mux : `SBS_BYTE_ZERO;
   end

   // Outputs, open drain pins pull low only
   assign RDATA_O = rdata_q;
   assign IRQ_O = |(istat_q & imask_q);
   assign SCL_O = 1'b0;
   assign SCL_OE_O = scll_q;
   assign SDA_O = 1'b0;
   assign SDA_OE_O = sdal_q;
endmodule
`default_nettype wire

// file: sbs_mst.sv
// Bus master model driving the two-wire serial bus
`default_nettype none
module sbs_mst (
   input wire logic clk_i, // System clock
   input wire logic scl_i, // Clock wire
   input wire logic sda_i, // Data wire
   output var logic scl_oe_o, // Pull clock low
   output var logic sda_oe_o, // Pull data low
   output var logic stuck_o // Clock never released
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus, both lines released
   initial
   begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
      stuck_o = 1'b0;
   end
   // Half of the 160 ns link period
   task automatic half();
      repeat (10) @(posedge clk_i);
   endtask
   task automatic start();
      sda_oe_o <= 1'b1;
      half();
      scl_oe_o <= 1'b1;
      half();
   endtask
   // Release the clock, waiting out any stretch
   task automatic rise();
      int n;
      n = 0;
      scl_oe_o <= 1'b0;
      @(posedge clk_i);
      while (!scl_i && n < 20000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (!scl_i)
         stuck_o <= 1'b1;
   endtask
   // One bit out, one sampled mid-high
   task automatic bitx(input logic b, output logic r);
      @(posedge clk_i);
      sda_oe_o <= !b;
      half();
      rise();
      repeat (5) @(posedge clk_i);
      r = sda_i;
      repeat (5) @(posedge clk_i);
      scl_oe_o <= 1'b1;
   endtask
   // Eight data bits then the acknowledge bit
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
         bitx(tx[i], rx[i]);
   endtask
   task automatic stop();
      @(posedge clk_i);
      sda_oe_o <= 1'b1;
      half();
      rise();
      half();
      sda_oe_o <= 1'b0;
      half();
   endtask
endmodule
`default_nettype wire

// file: sbs_slave_properties.sv
// Port checker for the serial bus slave
`default_nettype none
module sbs_slave_properties #(
   parameter int unsigned T_LOW_CYC = 4
) (
   input wire logic CLOCK_I, // Clock
   input wire logic SRST_I, // Reset
   input wire sbs_pkg::sbs_addr_t ADDR_I, // Address
   input wire sbs_pkg::sbs_byte_t WDATA_I, // Write data
   input wire logic WR_I, // Write strobe
   input wire logic RD_I, // Read strobe
   input wire sbs_pkg::sbs_byte_t RDATA_O, // Read data
   input wire logic IRQ_O, // Interrupt
   input wire logic SCL_I, // Clock pin
   input wire logic SCL_O, // Clock drive
   input wire logic SCL_OE_O, // Clock pull
   input wire logic SDA_I, // Data pin
   input wire logic SDA_O, // Data drive
   input wire logic SDA_OE_O // Data pull
);
   import sbs_pkg::*;
   logic [15:0] low_q;
   logic rel_q;
   // Software release request: buffer access or pin set
   wire logic rel_req = ((WR_I || RD_I) && ADDR_I == 8'h08) ||
      (WR_I && ADDR_I == 8'h00 && WDATA_I[2]);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   // Hold length and release seen during the hold
   always_ff @(posedge CLOCK_I)
   begin
      low_q <= (SRST_I || !SCL_OE_O) ? 16'h0000 : low_q + 16'h0001;
      rel_q <= !SRST_I && SCL_OE_O && (rel_q || rel_req);
   end
   AST_RD_IDLE: assert property (!RD_I |=> RDATA_O == 8'h00)
      else $error("read data not zero outside read");
   AST_OPEN_DRAIN: assert property (!SCL_O && !SDA_O)
      else $error("pin drive value not low");
   AST_HOLD_MIN: assert property ($fell(SCL_OE_O) |-> low_q >= T_LOW_CYC - 1)
      else $error("clock hold shorter than low period");
   AST_HOLD_CAUSE: assert property ($fell(SCL_OE_O) |-> rel_q)
      else $error("clock released without software action");
   AST_RELEASE: assert property (rel_q && low_q >= T_LOW_CYC |-> ##[0:6] !SCL_OE_O)
      else $error("clock not released after request");
   AST_ISTAT_CLR: assert property (RD_I && ADDR_I == 8'h10 && SCL_OE_O |-> ##2 !IRQ_O)
      else $error("interrupt stays after status read");
   AST_MASK_OFF: assert property (WR_I && ADDR_I == 8'h14 && WDATA_I == 8'h00 |-> ##2 !IRQ_O)
      else $error("interrupt stays while masked");
   AST_SDA_LOW: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I))
      else $error("data line moved while clock high");
   AST_STRETCH_LOW: assert property ($rose(SCL_OE_O) |-> !$past(SCL_I))
      else $error("stretch began with clock high");
   COV_HOLD: cover property ($rose(SCL_OE_O));
   COV_IRQ: cover property ($rose(IRQ_O));
   COV_SDA: cover property ($rose(SDA_OE_O));
endmodule
bind sbs_slave sbs_slave_properties #(.T_LOW_CYC(T_LOW_CYC)) u_sbs_slave_properties (
   .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .SCL_I(SCL_I),
   .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O),
   .SDA_OE_O(SDA_OE_O));
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the serial bus slave
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sbs_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   sbs_addr_t addr = 8'h00;
   sbs_byte_t wdata = 8'h00;
   sbs_byte_t rdata;
   logic irq, scl_oe, sda_oe, m_scl, m_sda, stuck, scl_o, sda_o;
   int failures = 0;
   int checks_done = 0;
   // Pulled-up wires, low when any party pulls
   wire logic scl = !(scl_oe || m_scl);
   wire logic sda = !(sda_oe || m_sda);
   always #4 clk = !clk;
   sbs_slave #(.T_LOW_CYC(4)) u_sbs_slave (.CLOCK_I(clk), .SRST_I(srst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .SCL_I(scl),
      .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe));
   sbs_mst u_sbs_mst (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl),
      .sda_oe_o(m_sda), .stuck_o(stuck));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rdr(a, d);
      chk(d, e);
   endtask
   task automatic stat(input logic [7:0] e, input logic [7:0] m);
      logic [7:0] d;
      rdr(8'h0C, d);
      chk(d & m, e);
   endtask
   // Bounded wait for the clock stretch
   task automatic hold();
      int n;
      n = 0;
      while (!scl_oe && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
      if (!scl_oe)
      begin
         failures++;
         results();
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic s_regs();
      rchk(8'h00, 8'h0C);
      rchk(8'h0C, 8'h10);
      wrr(8'h04, 8'h55);
      rchk(8'h04, 8'h54);
      rchk(8'h18, 8'h00);
      wrr(8'h14, 8'h01);
   endtask
   task automatic s_write();
      logic [8:0] r;
      logic [7:0] d;
      u_sbs_mst.start();
      u_sbs_mst.xfer({8'h54, 1'b1}, r);
      chk(r[0], 1'b0);
      hold();
      chk(irq, 1'b1);
      rchk(8'h10, 8'h01);
      stat(8'h04, 8'hCE);
      chk(irq, 1'b0);
      repeat (50) @(posedge clk);
      chk(scl_oe, 1'b1);
      rdr(8'h08, d);
      u_sbs_mst.xfer({8'hA5, 1'b1}, r);
      chk(r[0], 1'b0);
      hold();
      stat(8'h00, 8'hCE);
      rchk(8'h08, 8'hA5);
      u_sbs_mst.stop();
   endtask
   task automatic s_gcall();
      logic [8:0] r;
      logic [7:0] d;
      rdr(8'h10, d);
      wrr(8'h14, 8'h00);
      u_sbs_mst.start();
      u_sbs_mst.xfer({8'h00, 1'b1}, r);
      chk(r[0], 1'b0);
      hold();
      chk(irq, 1'b0);
      rchk(8'h10, 8'h01);
      stat(8'h06, 8'hCE);
      wrr(8'h00, 8'h0C);
      u_sbs_mst.xfer({8'h33, 1'b1}, r);
      hold();
      stat(8'h02, 8'hCE);
      rchk(8'h08, 8'h33);
      u_sbs_mst.stop();
      wrr(8'h14, 8'h01);
   endtask
   task automatic s_read();
      logic [8:0] r;
      u_sbs_mst.start();
      u_sbs_mst.xfer({8'h55, 1'b1}, r);
      hold();
      stat(8'h44, 8'hCE);
      wrr(8'h00, 8'h0A);
      wrr(8'h08, 8'hC3);
      u_sbs_mst.xfer({8'hFF, 1'b0}, r);
      chk(r[8:1], 8'hC3);
      hold();
      stat(8'h40, 8'hCE);
      wrr(8'h00, 8'h0A);
      wrr(8'h08, 8'h5A);
      u_sbs_mst.xfer({8'hFF, 1'b1}, r);
      chk(r[8:1], 8'h5A);
      hold();
      stat(8'h41, 8'hCF);
      wrr(8'h00, 8'h0E);
      wrr(8'h00, 8'h08);
      u_sbs_mst.stop();
      chk(sda, 1'b1);
   endtask
   // Lost arbitration: own read, own write, foreign address
   task automatic s_arb();
      logic [8:0] r;
      logic [7:0] d;
      logic [7:0] adr [3] = '{8'h55, 8'h54, 8'h20};
      logic [7:0] st [3] = '{8'h4C, 8'h0C, 8'h08};
      for (int i = 0; i < 3; i++)
      begin
         rdr(8'h10, d);
         wrr(8'h00, 8'h0B);
         wrr(8'h08, 8'hFF);
         u_sbs_mst.start();
         u_sbs_mst.xfer({adr[i], 1'b1}, r);
         hold();
         rchk(8'h10, 8'h03);
         stat(st[i], 8'hCE);
         wrr(8'h00, 8'h0C);
         u_sbs_mst.stop();
      end
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      s_regs();
      s_write();
      s_gcall();
      s_read();
      s_arb();
      chk(stuck, 1'b0);
      results();
   end
endmodule
`default_nettype wire
